// [rtl/ifs_pkg.sv]
// Constants shared by the instruction fetch sequencer files.
package ifs_pkg;
  // ---------------------------------------------------------------
  // Program memory geometry
  // ---------------------------------------------------------------
  localparam int          PC_W       = 10;
  localparam int          WORD_W     = 14;
  localparam int          LOW_W      = 8;
  localparam int          PHASES     = 4;
  localparam int          PH_W       = 2;
  // ---------------------------------------------------------------
  // Fixed vectors
  // ---------------------------------------------------------------
  localparam logic [9:0]  VEC_RESET  = 10'h000;
  localparam logic [9:0]  VEC_EXT    = 10'h004;
  localparam logic [9:0]  VEC_TIMER  = 10'h008;
  localparam logic [9:0]  VEC_ADC    = 10'h00C;
  localparam logic [1:0]  PH_LAST    = 2'h3;
  localparam logic [13:0] NOP_WORD   = 14'h0000;
  // ---------------------------------------------------------------
  // Control transfer requests from the execute datapath
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    IFS_XFER_NONE   = 3'h0,
    IFS_XFER_JUMP   = 3'h1,
    IFS_XFER_LOW    = 3'h2,
    IFS_XFER_RETURN = 3'h3,
    IFS_XFER_SKIP   = 3'h4
  } ifs_xfer_t;
  typedef enum logic [1:0] {
    IFS_INT_EXT   = 2'h0,
    IFS_INT_TIMER = 2'h1,
    IFS_INT_ADC   = 2'h2
  } ifs_int_t;
endpackage

// [rtl/ifs_phase_gen.sv]
// Four-phase clock generator for the instruction cycle.
module ifs_phase_gen
  import ifs_pkg::*;
(
  input  wire logic             i_clk,
  input  wire logic             i_rst,
  output logic [PHASES-1:0]     o_phase,
  output logic                  o_cycle_end
);
  logic [PH_W-1:0]   cnt_r;
  logic [PH_W-1:0]   cnt_nxt;
  logic [PHASES-1:0] phase_r;
  logic [PHASES-1:0] phase_nxt;

  // Exactly one phase is high in each system clock period.
  always_comb begin
    cnt_nxt   = cnt_r + 2'h1;
    phase_nxt = {phase_r[PHASES-2:0], phase_r[PHASES-1]};
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cnt_r   <= 2'h0;
      phase_r <= 4'h1;
    end else begin
      cnt_r   <= cnt_nxt;
      phase_r <= phase_nxt;
    end
  end

  assign o_phase     = phase_r;
  assign o_cycle_end = (cnt_r == PH_LAST);
endmodule

// [rtl/ifs_sequencer.sv]
// Instruction fetch sequencer: phase timing, program counter and pipeline.
// Summary of operation
// - System clock splits into four phases; one instruction cycle is four clocks.
// - Fetch in one cycle, execute in the next, overlapped with the next fetch.
// - An instruction that changes the program counter takes two cycles.
// - No instruction takes more than two machine cycles.
// - Program counter advances by one after each fetch.
// - Program counter spans a 1024 by 14 program memory.
// - External clear input is active low and initialises the sequencer.
// - After reset the program counter starts at address 000H.
// - A met skip discards the fetched instruction and runs a dummy cycle.
// - A counter_low_byte write replaces low eight bits, keeping upper bits.
// - Accepted interrupts vector to 004H, 008H or 00CH if the stack has room.
module ifs_sequencer
  import ifs_pkg::*;
#(
  parameter int ADDR_W = PC_W,
  parameter int DATA_W = WORD_W
) (
  input  wire logic                i_clk,
  input  wire logic                i_rst,
  input  wire logic                i_chip_clear_input_n,
  input  wire logic [DATA_W-1:0]   i_rom_data,
  input  wire ifs_pkg::ifs_xfer_t  i_xfer,
  input  wire logic [ADDR_W-1:0]   i_target,
  input  wire logic [LOW_W-1:0]    i_counter_low_byte,
  input  wire logic                i_int_req,
  input  wire ifs_pkg::ifs_int_t   i_int_src,
  input  wire logic                i_stack_full,
  output logic [ADDR_W-1:0]        o_rom_addr,
  output logic                     o_rom_rd,
  output logic [DATA_W-1:0]        o_exec_word,
  output logic                     o_exec_valid,
  output logic                     o_exec_start,
  output logic [ADDR_W-1:0]        o_pc,
  output logic [ADDR_W-1:0]        o_push_addr,
  output logic                     o_int_ack,
  output logic [PHASES-1:0]        o_phase
);
  import ifs_pkg::*;

  // ---------------------------------------------------------------
  // Pipeline states
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    IFS_ST_RESET = 2'b00,
    IFS_ST_RUN   = 2'b01,
    IFS_ST_DUMMY = 2'b11
  } ifs_state_t;

  logic [PHASES-1:0] phase;
  logic              cycle_end;
  logic              clear_r;
  logic              clear_nxt;

  // ---------------------------------------------------------------
  // Phase generator
  // ---------------------------------------------------------------
  ifs_phase_gen u_phase (
    .i_clk       (i_clk),
    .i_rst       (clear_r),
    .o_phase     (phase),
    .o_cycle_end (cycle_end)
  );

  ifs_state_t        state_r;
  ifs_state_t        state_nxt;
  logic [ADDR_W-1:0] pc_r;
  logic [ADDR_W-1:0] pc_nxt;
  logic [DATA_W-1:0] fetch_r;
  logic [DATA_W-1:0] fetch_nxt;
  logic [DATA_W-1:0] exec_r;
  logic [DATA_W-1:0] exec_nxt;
  logic              valid_r;
  logic              valid_nxt;
  logic              start_r;
  logic              start_nxt;
  logic              rd_r;
  logic              rd_nxt;
  logic              ack_r;
  logic              ack_nxt;
  logic [ADDR_W-1:0] push_r;
  logic [ADDR_W-1:0] push_nxt;
  logic [PHASES-1:0] phase_r;
  logic [ADDR_W-1:0] vec;

  // Clear is held while the pin is low; the whole sequencer restarts from it.
  always_comb begin
    clear_nxt = ~i_chip_clear_input_n;
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      clear_r <= 1'b1;
    end else begin
      clear_r <= clear_nxt;
    end
  end

  always_comb begin
    case (i_int_src)
      IFS_INT_EXT:   vec = ADDR_W'(VEC_EXT);
      IFS_INT_TIMER: vec = ADDR_W'(VEC_TIMER);
      default:       vec = ADDR_W'(VEC_ADC);
    endcase
  end

  // ---------------------------------------------------------------
  // Fetch, execute and counter update at the end of each cycle
  // ---------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    pc_nxt    = pc_r;
    fetch_nxt = fetch_r;
    exec_nxt  = exec_r;
    valid_nxt = valid_r;
    start_nxt = 1'b0;
    rd_nxt    = (phase[0] == 1'b1) && (state_r != IFS_ST_RESET);
    ack_nxt   = 1'b0;
    push_nxt  = push_r;
    // The word read in the second phase is held by the memory and taken in the last.
    if (phase[PHASES-1]) begin
      fetch_nxt = i_rom_data;
    end
    if (cycle_end) begin
      start_nxt = 1'b1;
      case (state_r)
        IFS_ST_RESET: begin
          pc_nxt    = ADDR_W'(VEC_RESET);
          valid_nxt = 1'b0;
          exec_nxt  = NOP_WORD;
          state_nxt = IFS_ST_DUMMY;
        end
        IFS_ST_DUMMY: begin
          // The dummy slot is over; the word fetched during it executes next.
          exec_nxt  = fetch_nxt;
          valid_nxt = 1'b1;
          pc_nxt    = pc_r + 10'h001;
          state_nxt = IFS_ST_RUN;
        end
        default: begin
          exec_nxt  = fetch_nxt;
          valid_nxt = 1'b1;
          pc_nxt    = pc_r + 10'h001;
          if (i_int_req && !i_stack_full) begin
            push_nxt  = pc_r;
            ack_nxt   = 1'b1;
            pc_nxt    = vec;
            state_nxt = IFS_ST_DUMMY;
            valid_nxt = 1'b0;
            exec_nxt  = NOP_WORD;
          end else begin
            case (i_xfer)
              IFS_XFER_JUMP, IFS_XFER_RETURN: begin
                pc_nxt    = i_target;
                state_nxt = IFS_ST_DUMMY;
              end
              IFS_XFER_LOW: begin
                pc_nxt    = {pc_r[ADDR_W-1:LOW_W], i_counter_low_byte};
                state_nxt = IFS_ST_DUMMY;
              end
              IFS_XFER_SKIP: begin
                state_nxt = IFS_ST_DUMMY;
              end
              default: begin
                state_nxt = IFS_ST_RUN;
              end
            endcase
            if (i_xfer != IFS_XFER_NONE) begin
              // The prefetched word is discarded; the slot becomes a dummy.
              valid_nxt = 1'b0;
              exec_nxt  = NOP_WORD;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      state_r <= IFS_ST_RESET;
      pc_r    <= 10'h000;
      fetch_r <= 14'h0000;
      exec_r  <= 14'h0000;
      valid_r <= 1'b0;
      start_r <= 1'b0;
      rd_r    <= 1'b0;
      ack_r   <= 1'b0;
      push_r  <= 10'h000;
      phase_r <= 4'h0;
    end else if (clear_r) begin
      state_r <= IFS_ST_RESET;
      pc_r    <= 10'h000;
      fetch_r <= 14'h0000;
      exec_r  <= 14'h0000;
      valid_r <= 1'b0;
      start_r <= 1'b0;
      rd_r    <= 1'b0;
      ack_r   <= 1'b0;
      push_r  <= 10'h000;
      phase_r <= 4'h0;
    end else begin
      state_r <= state_nxt;
      pc_r    <= pc_nxt;
      fetch_r <= fetch_nxt;
      exec_r  <= exec_nxt;
      valid_r <= valid_nxt;
      start_r <= start_nxt;
      rd_r    <= rd_nxt;
      ack_r   <= ack_nxt;
      push_r  <= push_nxt;
      phase_r <= phase;
    end
  end

  assign o_rom_addr   = pc_r;
  assign o_rom_rd     = rd_r;
  assign o_exec_word  = exec_r;
  assign o_exec_valid = valid_r;
  assign o_exec_start = start_r;
  assign o_pc         = pc_r;
  assign o_push_addr  = push_r;
  assign o_int_ack    = ack_r;
  assign o_phase      = phase_r;
endmodule

// [test/ifs_sequencer_properties.sv]
// Port-level timing checks for the instruction fetch sequencer.
module ifs_sequencer_checker
  import ifs_pkg::*;
#(
  parameter int ADDR_W = PC_W,
  parameter int DATA_W = WORD_W
) (
  input wire logic               i_clk,
  input wire logic               i_rst,
  input wire logic               i_chip_clear_input_n,
  input wire logic [DATA_W-1:0]  i_rom_data,
  input wire ifs_pkg::ifs_xfer_t i_xfer,
  input wire logic [ADDR_W-1:0]  i_target,
  input wire logic [LOW_W-1:0]   i_counter_low_byte,
  input wire logic               i_int_req,
  input wire ifs_pkg::ifs_int_t  i_int_src,
  input wire logic               i_stack_full,
  input wire logic [ADDR_W-1:0]  o_rom_addr,
  input wire logic               o_rom_rd,
  input wire logic [DATA_W-1:0]  o_exec_word,
  input wire logic               o_exec_valid,
  input wire logic               o_exec_start,
  input wire logic [ADDR_W-1:0]  o_pc,
  input wire logic [ADDR_W-1:0]  o_push_addr,
  input wire logic               o_int_ack,
  input wire logic [PHASES-1:0]  o_phase
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst || !i_chip_clear_input_n);
  logic              take_int;
  logic              quiet;
  logic [ADDR_W-9:0] pc_hi;
  assign take_int = i_int_req && !i_stack_full;
  assign quiet    = i_xfer == IFS_XFER_NONE && !take_int;
  assign pc_hi    = o_pc[ADDR_W-1:8];
  logic [PHASES-1:0] phase_rot;
  assign phase_rot = {o_phase[PHASES-2:0], o_phase[PHASES-1]};
  a_start_every_four: assert property (
      o_exec_start |=> !o_exec_start [*3] ##1 o_exec_start)
    else $error("start pulse spacing wrong");
  a_pc_stands: assert property (o_exec_start |=> $stable(o_pc) [*3])
    else $error("pc moved inside a cycle");
  a_phase_rotates: assert property (
      o_phase != '0 |=> o_phase == $past(phase_rot))
    else $error("phase did not rotate");
  a_one_fetch: assert property (o_rom_rd |=> !o_rom_rd [*3])
    else $error("more than one fetch per cycle");
  a_pc_step: assert property (
      (o_exec_start && o_pc != 0) ##3 quiet |=> o_pc == $past(o_pc) + 1'b1)
    else $error("pc did not step by one");
  a_jump_lands: assert property ((o_exec_start && o_exec_valid) ##3
      (i_xfer == IFS_XFER_JUMP && !take_int) |=> o_pc == $past(i_target))
    else $error("jump target not loaded");
  a_low_load: assert property ((o_exec_start && o_exec_valid) ##3
      (i_xfer == IFS_XFER_LOW && !take_int) |=> o_pc[7:0] == $past(i_counter_low_byte)
      && $stable(pc_hi))
    else $error("low byte load wrong");
  a_dummy_follows: assert property ((o_exec_start && o_exec_valid) ##3 !quiet
      |=> !o_exec_valid [*4])
    else $error("no dummy cycle after transfer");
  a_int_vector: assert property ((o_exec_start && o_exec_valid) ##3 take_int
      |=> o_int_ack && o_pc == {$past(i_int_src) + 2'h1, 2'h0})
    else $error("interrupt vector wrong");
  a_int_refused: assert property (i_stack_full |=> !o_int_ack)
    else $error("interrupt taken with full stack");
  a_clear_holds: assert property (disable iff (i_rst)
      !i_chip_clear_input_n [*3] |-> o_pc == '0 && !o_exec_valid)
    else $error("chip clear did not hold pc at zero");
  c_int: cover property (o_int_ack);
  c_dummy: cover property (o_exec_start && !o_exec_valid);
  c_clear: cover property (!i_chip_clear_input_n);
endmodule

bind ifs_sequencer ifs_sequencer_checker #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) u_chk (.*);

// [test/ifs_rom_model.sv]
// Program memory model; a read word holds until the next read.
module ifs_rom_model
  import ifs_pkg::*;
(
  input  wire logic              i_clk,
  input  wire logic              i_rd,
  input  wire logic [PC_W-1:0]   i_addr,
  output logic      [WORD_W-1:0] o_data
);
  initial o_data = '0;
  always @(posedge i_clk) if (i_rd) o_data <= {4'hA, i_addr};
endmodule

// [test/instruction_fetch_sequencer_tb.sv]
// Self-checking bench for the instruction fetch sequencer.
module instruction_fetch_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import ifs_pkg::*;
  logic        clk = 0, rst = 1, clr_n = 1, int_req = 0, full = 0;
  logic        rd, ack, valid, start;
  logic [9:0]  target = '0, exp_pc, prev_pc, pc, addr, push;
  logic [7:0]  low = '0;
  logic [13:0] rom_data, word;
  ifs_xfer_t   xfer = IFS_XFER_NONE;
  ifs_int_t    src = IFS_INT_EXT;
  bit          exp_v, took;
  int          mismatches = 0, tests_run = 0;

  ifs_sequencer u_dut (.i_clk(clk), .i_rst(rst), .i_chip_clear_input_n(clr_n),
    .i_rom_data(rom_data), .i_xfer(xfer), .i_target(target), .i_counter_low_byte(low),
    .i_int_req(int_req), .i_int_src(src), .i_stack_full(full), .o_rom_addr(addr),
    .o_rom_rd(rd), .o_exec_word(word), .o_exec_valid(valid), .o_exec_start(start),
    .o_pc(pc), .o_push_addr(push), .o_int_ack(ack), .o_phase());
  ifs_rom_model u_rom (.i_clk(clk), .i_rd(rd), .i_addr(addr), .o_data(rom_data));

  initial forever #5 clk = ~clk;

  task automatic check(string name, logic [13:0] exp, logic [13:0] got);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic next_start();
    int n = 0;
    do begin
      @(posedge clk);
      #1;
    end while (start !== 1'b1 && ++n < 20);
  endtask

  task automatic sync();
    int k = 0;
    do next_start(); while (pc !== 10'h001 && ++k < 20);
    exp_pc = 10'h001;
    exp_v = 1;
  endtask

  task automatic step(ifs_xfer_t x, bit irq, bit f, ifs_int_t s);
    xfer = x;
    int_req = irq;
    full = f;
    src = s;
    target = 10'($urandom);
    low = 8'($urandom);
    prev_pc = exp_pc;
    took = exp_v && irq && !f;
    if (took) exp_pc = {s + 2'h1, 2'h0};
    else if (exp_v && x == IFS_XFER_LOW) exp_pc[7:0] = low;
    else if (exp_v && (x == IFS_XFER_JUMP || x == IFS_XFER_RETURN)) exp_pc = target;
    else exp_pc = exp_pc + 10'h001;
    exp_v = !(took || (exp_v && x != IFS_XFER_NONE));
    next_start();
    check("pc", exp_pc, pc);
    check("valid", exp_v, valid);
    check("ack", took, ack);
    if (took) check("push", prev_pc, push);
    if (exp_v) check("word", {4'hA, prev_pc}, word);
  endtask

  task automatic conclude();
    if (mismatches == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial begin
    void'($urandom(32'h6434));
    repeat (5) @(posedge clk);
    #1 rst = 0;
    sync();
    for (int i = 0; i < 3; i++) begin
      step(IFS_XFER_NONE, 1, 0, ifs_int_t'(i));
      step(IFS_XFER_NONE, 1, 1, IFS_INT_EXT);
    end
    for (int i = 1; i < 5; i++) begin
      step(ifs_xfer_t'(i), 0, 0, IFS_INT_EXT);
      step(ifs_xfer_t'(i), 0, 0, IFS_INT_EXT);
    end
    for (int i = 0; i < 80; i++) begin
      step(ifs_xfer_t'($urandom % 5), $urandom % 6 == 0, $urandom % 2, ifs_int_t'($urandom % 3));
    end
    clr_n = 0;
    repeat (3) @(posedge clk);
    #1 check("clear pc", 14'h0000, pc);
    check("clear valid", 14'h0000, valid);
    clr_n = 1;
    sync();
    step(IFS_XFER_NONE, 0, 0, IFS_INT_EXT);
    conclude();
  end

  initial begin
    repeat (5000) @(posedge clk);
    mismatches++;
    conclude();
  end
endmodule
